// ==== verilog/ceo_pkg.sv ====
/*
 * Shared constants for the emulated-op execution unit: operation codes,
 * flags_word bit positions, masks and reset values.
 * Assumes a single clock domain and a decoder that presents one op per cycle.
 */
package ceo_pkg;
	typedef enum logic [2:0] {
		CEO_OP_NONE,
		CEO_OP_SUB2,
		CEO_OP_ADD1,
		CEO_OP_ADD2,
		CEO_OP_INV,
		CEO_OP_IRQ_OFF,
		CEO_OP_IRQ_ON,
		CEO_OP_BR_CARRY
	} ceo_op_t;

	localparam int CEO_DATA_W = 16;
	localparam int CEO_PC_W = 20;
	localparam int CEO_OFS_W = 10;

	// flags_word bit positions
	localparam int CEO_BIT_C = 0;
	localparam int CEO_BIT_Z = 1;
	localparam int CEO_BIT_N = 2;
	localparam int CEO_BIT_GIE = 3;
	localparam int CEO_BIT_CPU_HALT = 4;
	localparam int CEO_BIT_OSC_HALT = 5;
	localparam int CEO_BIT_V = 8;

	localparam logic [15:0] CEO_IRQ_MASK = 16'h0008;
	localparam logic [15:0] CEO_IRQ_OFF_MASK = 16'hFFF7;
	localparam logic [15:0] CEO_FLAGS_RST = 16'h0000;
	localparam logic [15:0] CEO_DATA_RST = 16'h0000;
	localparam logic [19:0] CEO_PC_RST = 20'h00000;

	// Constants used by the arithmetic ops and the PC increment
	localparam logic [15:0] CEO_STEP_ONE = 16'h0001;
	localparam logic [15:0] CEO_STEP_TWO = 16'h0002;
	localparam logic [15:0] CEO_WORD_ONES = 16'hFFFF;
	localparam logic [15:0] CEO_BYTE_ONES = 16'h00FF;
	localparam logic [19:0] CEO_PC_STEP = 20'h00002;
endpackage : ceo_pkg

// ==== verilog/ceo_alu.sv ====
/*
 * Combinational arithmetic for the emulated single-operand ops.
 * Assumes the operand is already fetched; byte mode uses bits 7:0 only.
 */
`timescale 1ns/1ps
`default_nettype none
module ceo_alu (
	input wire ceo_pkg::ceo_op_t i_op,
	input wire logic i_byte,
	input wire logic [15:0] i_dst,
	output logic [15:0] o_res,
	output logic o_n,
	output logic o_z,
	output logic o_c,
	output logic o_v
);
	logic [16:0] sum;
	logic [15:0] mask;
	logic [15:0] a;
	logic [15:0] r;
	logic sa;
	logic sr;
	logic cy;

	always_comb begin
		mask = i_byte ? ceo_pkg::CEO_BYTE_ONES : ceo_pkg::CEO_WORD_ONES;
		a = i_dst & mask;
		sum = 17'h00000;
		cy = 1'b0;
		unique case (i_op)
			// [RULE1] subtract two
			ceo_pkg::CEO_OP_SUB2: begin
				sum = {1'b0, a} + {1'b0, ~ceo_pkg::CEO_STEP_TWO & mask} + 17'h00001;
			end
			// [RULE10] add one
			ceo_pkg::CEO_OP_ADD1: begin
				sum = {1'b0, a} + {1'b0, ceo_pkg::CEO_STEP_ONE};
			end
			// [RULE12] add two
			ceo_pkg::CEO_OP_ADD2: begin
				sum = {1'b0, a} + {1'b0, ceo_pkg::CEO_STEP_TWO};
			end
			// [RULE14] invert all bits
			ceo_pkg::CEO_OP_INV: begin
				sum = {1'b0, a ^ mask};
			end
			default: begin
				sum = {1'b0, a};
			end
		endcase
		r = sum[15:0] & mask;
		// Carry out sits at bit 8 for bytes, bit 16 for words
		// [RULE2] carry means no borrow
		cy = i_byte ? sum[8] : sum[16];
		// [RULE18] sign from width msb
		sa = i_byte ? a[7] : a[15];
		sr = i_byte ? r[7] : r[15];
		o_res = r;
		o_n = sr;
		o_z = (r == 16'h0000);
		o_c = cy;
		o_v = 1'b0;
		unique case (i_op)
			// [RULE3] overflow pos from neg
			ceo_pkg::CEO_OP_SUB2: o_v = sa & ~sr;
			// [RULE11] overflow at max
			// [RULE13] overflow near max
			ceo_pkg::CEO_OP_ADD1: o_v = ~sa & sr;
			ceo_pkg::CEO_OP_ADD2: o_v = ~sa & sr;
			// [RULE15] carry is not zero
			ceo_pkg::CEO_OP_INV: begin
				o_c = (r != 16'h0000);
				o_v = sa;
			end
			default: o_v = 1'b0;
		endcase
	end
endmodule : ceo_alu
`default_nettype wire

// ==== verilog/ceo_exec.sv ====
/*
 * Execution unit for subtract_two, add_one, add_two, bitwise_complement,
 * global_irq_off/on and branch_if_carry, holding flags_word and the PC.
 * Assumes a decoder issuing one op per cycle with a fetched destination,
 * and an interrupt controller that honours o_irq_hold.
 */
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] subtract_two lowers destination by two
// [RULE2] subtract_two sets N, Z, C from result
// [RULE3] subtract_two overflow only at sign boundary
// [RULE4] global_irq_off clears only the enable bit
// [RULE5] Software waits one instruction after disable
// [RULE6] Software never disables right after enable
// [RULE7] global_irq_on sets only the enable bit
// [RULE8] Instruction after enable always runs first
// [RULE9] Software spaces flag clear before enable
// [RULE10] add_one sets Z and C on wrap
// [RULE11] add_one overflow at max positive value
// [RULE12] add_two Z and C on wrap
// [RULE13] add_two overflow near max positive value
// [RULE14] bitwise_complement inverts every destination bit
// [RULE15] Complement: C is not Z, V old sign
// [RULE16] Carry branch adds doubled offset to PC
// [RULE17] Branch keeps flags; ops keep mode bits
// [RULE18] N is msb at selected width
module ceo_exec (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_valid,
	input wire ceo_pkg::ceo_op_t i_op,
	input wire logic i_byte,
	input wire logic [15:0] i_dst,
	input wire logic [9:0] i_offset,
	output logic o_done,
	output logic [15:0] o_result,
	output logic o_result_we,
	output logic [15:0] o_flags_word,
	output logic [19:0] o_pc,
	output logic o_branch_taken,
	output logic o_irq_hold
);
	logic [15:0] alu_res;
	logic alu_n;
	logic alu_z;
	logic alu_c;
	logic alu_v;

	logic [15:0] flags_q, flags_d;
	logic [19:0] pc_q, pc_d;
	logic [15:0] result_q, result_d;
	logic result_we_q, result_we_d;
	logic done_q, done_d;
	logic taken_q, taken_d;
	logic hold_q, hold_d;
	logic [19:0] ofs_ext;
	logic arith;

	ceo_alu u_alu (
		.i_op(i_op),
		.i_byte(i_byte),
		.i_dst(i_dst),
		.o_res(alu_res),
		.o_n(alu_n),
		.o_z(alu_z),
		.o_c(alu_c),
		.o_v(alu_v)
	);

	always_comb begin
		flags_d = flags_q;
		pc_d = pc_q;
		result_d = result_q;
		result_we_d = 1'b0;
		done_d = 1'b0;
		taken_d = 1'b0;
		// [RULE8] hold cleared after next op
		hold_d = hold_q & ~i_valid;
		// Signed word offset doubled, then sign extended to PC width
		ofs_ext = {{(ceo_pkg::CEO_PC_W - ceo_pkg::CEO_OFS_W - 1){i_offset[9]}},
			i_offset, 1'b0};
		arith = (i_op == ceo_pkg::CEO_OP_SUB2) || (i_op == ceo_pkg::CEO_OP_ADD1)
			|| (i_op == ceo_pkg::CEO_OP_ADD2) || (i_op == ceo_pkg::CEO_OP_INV);
		if (i_valid) begin
			done_d = 1'b1;
			pc_d = pc_q + ceo_pkg::CEO_PC_STEP;
			if (arith) begin
				// [RULE1] write back result
				result_d = alu_res;
				result_we_d = 1'b1;
				// [RULE17] mode bits untouched
				flags_d[ceo_pkg::CEO_BIT_N] = alu_n;
				flags_d[ceo_pkg::CEO_BIT_Z] = alu_z;
				flags_d[ceo_pkg::CEO_BIT_C] = alu_c;
				flags_d[ceo_pkg::CEO_BIT_V] = alu_v;
			end
			unique case (i_op)
				// [RULE4] clear enable only
				ceo_pkg::CEO_OP_IRQ_OFF: begin
					flags_d = flags_q & ceo_pkg::CEO_IRQ_OFF_MASK;
				end
				// [RULE7] set enable only
				ceo_pkg::CEO_OP_IRQ_ON: begin
					flags_d = flags_q | ceo_pkg::CEO_IRQ_MASK;
					// [RULE8] shield next op
					hold_d = 1'b1;
				end
				// [RULE16] carry branch target
				ceo_pkg::CEO_OP_BR_CARRY: begin
					if (flags_q[ceo_pkg::CEO_BIT_C]) begin
						pc_d = pc_q + ofs_ext;
						taken_d = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			flags_q <= ceo_pkg::CEO_FLAGS_RST;
			pc_q <= ceo_pkg::CEO_PC_RST;
			result_q <= ceo_pkg::CEO_DATA_RST;
			result_we_q <= 1'b0;
			done_q <= 1'b0;
			taken_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			pc_q <= pc_d;
			result_q <= result_d;
			result_we_q <= result_we_d;
			done_q <= done_d;
			taken_q <= taken_d;
			hold_q <= hold_d;
		end
	end

	assign o_flags_word = flags_q;
	assign o_pc = pc_q;
	assign o_result = result_q;
	assign o_result_we = result_we_q;
	assign o_done = done_q;
	assign o_branch_taken = taken_q;
	assign o_irq_hold = hold_q;
endmodule : ceo_exec
`default_nettype wire

// ==== verif/ceo_exec_properties.sv ====
/* Assertions on ceo_exec result and flags_word behaviour.
   Assumes it is bound to every ceo_exec instance. */
`timescale 1ns/1ps
`default_nettype none
module ceo_exec_properties (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_valid,
	input wire ceo_pkg::ceo_op_t i_op,
	input wire logic i_byte,
	input wire logic [15:0] i_dst,
	input wire logic [15:0] o_result,
	input wire logic [15:0] o_flags_word,
	input wire logic o_irq_hold
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	logic w;
	assign w = i_valid && !i_byte;
	a_sub2_result: assert property (
		w && i_op == ceo_pkg::CEO_OP_SUB2 |=> o_result == $past(i_dst) - 16'h0002)
		else $error("sub2 result");
	a_sub2_ovf: assert property (
		w && i_op == ceo_pkg::CEO_OP_SUB2
		|=> o_flags_word[8] == ($past(i_dst[15:1]) == 15'h4000))
		else $error("sub2 overflow");
	a_irq_off_mask: assert property (
		i_valid && i_op == ceo_pkg::CEO_OP_IRQ_OFF
		|=> o_flags_word == ($past(o_flags_word) & 16'hFFF7))
		else $error("irq off");
	a_irq_on_mask: assert property (
		i_valid && i_op == ceo_pkg::CEO_OP_IRQ_ON
		|=> o_flags_word == ($past(o_flags_word) | 16'h0008))
		else $error("irq on");
	a_irq_hold_next: assert property (
		i_valid && i_op == ceo_pkg::CEO_OP_IRQ_ON |=> o_irq_hold)
		else $error("irq hold");
	a_hold_clears: assert property (
		o_irq_hold && i_valid && i_op != ceo_pkg::CEO_OP_IRQ_ON |=> !o_irq_hold)
		else $error("irq hold clear");
	a_inc_wrap: assert property (
		w && i_op == ceo_pkg::CEO_OP_ADD1
		|=> o_flags_word[1:0] == {2{$past(i_dst) == 16'hFFFF}})
		else $error("add1 wrap");
	a_inv_carry: assert property (
		i_valid && i_op == ceo_pkg::CEO_OP_INV
		|=> o_flags_word[0] != o_flags_word[1])
		else $error("inv carry");
	a_branch_keeps: assert property (
		i_valid && i_op == ceo_pkg::CEO_OP_BR_CARRY |=> $stable(o_flags_word))
		else $error("branch flags");
	c_branch: cover property (i_valid && i_op == ceo_pkg::CEO_OP_BR_CARRY);
	c_byte_op: cover property (i_valid && i_byte);
	c_hold: cover property (o_irq_hold);
endmodule : ceo_exec_properties
bind ceo_exec ceo_exec_properties u_props (
	.i_mclk(i_mclk),
	.i_reset(i_reset),
	.i_valid(i_valid),
	.i_op(i_op),
	.i_byte(i_byte),
	.i_dst(i_dst),
	.o_result(o_result),
	.o_flags_word(o_flags_word),
	.o_irq_hold(o_irq_hold)
);
`default_nettype wire

// ==== verif/ceo_exec_tb_top.sv ====
/* Testbench for ceo_exec: a table of back-to-back ops with expectations.
   Assumes ceo_pkg and ceo_exec are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module ceo_exec_tb_top;
	logic i_mclk = 1'h0;
	logic i_reset = 1'h1;
	logic i_valid = 1'h0;
	ceo_pkg::ceo_op_t i_op = ceo_pkg::CEO_OP_NONE;
	logic i_byte = 1'h0;
	logic [15:0] i_dst = 16'h0000;
	logic [9:0] i_offset = 10'h000;
	logic [15:0] res, flags, pf = 16'h0000;
	logic [19:0] pc, epc = 20'h00000;
	logic done, tk, hold, etk, we;
	localparam int OP_COUNT = 28;
	int err_total = 0;
	int check_count = 0;
	// Nibble op*2+byte, dst (bits 9:0 double as branch offset), result, flags
	// no-op after each irq off
	// irq off never right after on
	logic [51:0] t [OP_COUNT] = '{
		52'hC000000000008, 52'h200020000000B, 52'h280017FFF0109,
		52'h3000100FF000C, 52'h4FFFF0000000B, 52'h5007F0080010C,
		52'h6FFFE0000000B, 52'h7007E0080010C, 52'h800AEFF51000D,
		52'h900FF0000010A, 52'hE00000000010A, 52'h4000000010008,
		52'h6FFFF00010009, 52'hE01FF00010009, 52'hA000000010001,
		52'h0000000010001, 52'h30080007E0101, 52'h30081007F0101,
		52'h47FFF80000104, 52'h67FFE80000104, 52'h880007FFF0101,
		52'hE02007FFF0101, 52'h20000FFFE0004, 52'hE0155FFFE0004,
		52'hC0000FFFE000C, 52'h00000FFFE000C, 52'hA0000FFFE0004,
		52'h00000FFFE0004};
	always #12.5 i_mclk = ~i_mclk;
	ceo_exec u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_valid(i_valid),
		.i_op(i_op), .i_byte(i_byte), .i_dst(i_dst), .i_offset(i_offset),
		.o_done(done), .o_result(res), .o_result_we(we),
		.o_flags_word(flags), .o_pc(pc), .o_branch_taken(tk),
		.o_irq_hold(hold));
	task chk(input logic [19:0] g, input logic [19:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	task check(input logic [51:0] r);
		etk = r[51:49] == 3'h7 && pf[0];
		epc = etk ? epc + {{9{r[41]}}, r[41:32], 1'h0} : epc + 20'h00002;
		chk(20'(res), 20'(r[31:16]));
		chk(20'(we), 20'(r[51:49] >= 3'h1 && r[51:49] <= 3'h4));
		chk(20'(flags), 20'(r[15:0]));
		chk(20'(flags[3]), 20'(r[3]));
		chk(pc, epc);
		chk(20'(tk), 20'(etk));
		chk(20'(hold), 20'(r[51:49] == 3'h6));
		chk(20'(done), 20'h00001);
		pf = r[15:0];
	endtask : check
	task summarize();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	initial begin
		repeat (8) @(negedge i_mclk);
		i_reset = 1'h0;
		for (int i = 0; i <= OP_COUNT; i++) begin
			@(negedge i_mclk);
			if (i > 0)
				check(t[i - 1]);
			if (i < OP_COUNT) begin
				i_op = ceo_pkg::ceo_op_t'(t[i][51:49]);
				i_byte = t[i][48];
				i_dst = t[i][47:32];
				i_offset = t[i][41:32];
			end
			i_valid = i < OP_COUNT;
		end
		summarize();
	end
	// About 40 cycles are needed; 300 means a hang
	initial begin
		#(300 * 25);
		err_total++;
		summarize();
	end
endmodule : ceo_exec_tb_top
`default_nettype wire
